// *** design/buf_param_check.sv ***
// decodes and checks a received buffer parameter word
// purely combinational; the caller registers the results
`timescale 1ns/100ps
`default_nettype none
module buf_param_check (
   input wire logic [31:0] param,
   input wire logic [11:0] login_size,
   output logic multi,
   output logic [11:0] size,
   output logic size_ok,
   output logic [11:0] usable
);
   // reserved bits 30..12 are ignored on reception
   assign multi = param[els_pkg::MF_BIT];
   assign size = param[els_pkg::SIZE_MSB:0];
   // unaligned or out-of-range sizes are flagged as errors
   assign size_ok = (size[1:0] == 2'h0) && (size >= els_pkg::SIZE_MIN)
      && (size <= els_pkg::SIZE_MAX);
   // usable size is the smaller of reported and login size
   assign usable = (size < login_size) ? size : login_size;
endmodule
`default_nettype wire

// *** design/els_link_if.sv ***
// word-wide link between requester and responder, both on clk_sys
// assumes each party always accepts a word offered to it
`timescale 1ns/100ps
`default_nettype none
interface els_link_if;
   logic req_vld;
   logic [31:0] req_data;
   logic req_last;
   logic [23:0] req_sid;
   logic [23:0] req_did;
   logic rpy_vld;
   logic [31:0] rpy_data;
   logic rpy_last;
   logic [23:0] rpy_sid;
   logic [23:0] rpy_did;

   modport requester (
      output req_vld, req_data, req_last, req_sid, req_did,
      input rpy_vld, rpy_data, rpy_last, rpy_sid, rpy_did
   );
   modport responder (
      input req_vld, req_data, req_last, req_sid, req_did,
      output rpy_vld, rpy_data, rpy_last, rpy_sid, rpy_did
   );
endinterface
`default_nettype wire

// *** design/els_pkg.sv ***
// constants shared by both ends of the port buffer report exchange
// assumes a single system clock and word-wide link transfers
`default_nettype none
package els_pkg;

   // payload codes
   localparam logic [7:0] CMD_PORT_BUF = 8'h58;   // request command code
   localparam logic [7:0] ACC_CODE = 8'h02;
   localparam logic [7:0] RJT_CODE = 8'h01;
   localparam logic [7:0] RSN_NOT_SUPP = 8'h0b;   // command not supported
   localparam logic [7:0] RSN_LOGICAL = 8'h03;    // malformed or invalid request
   localparam int CODE_LSB = 24;

   // fabric port controller well-known address
   localparam logic [23:0] FPORT_CTRL_ID = 24'h0f_fffe;

   // buffer parameter word layout
   localparam int MF_BIT = 31;
   localparam int SIZE_MSB = 11;
   localparam logic [11:0] SIZE_MIN = 12'h100;    // 256 bytes
   localparam logic [11:0] SIZE_MAX = 12'h840;    // 2112 bytes

   // word counts of the sequences
   localparam logic [1:0] REQ_WORDS = 2'h3;
   localparam logic [1:0] RPY_WORDS = 2'h2;

   // responder register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_OWN_SIZE = 8'h04;
   localparam logic [7:0] REG_LOGIN_SIZE = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_COUNT = 8'h10;
   localparam logic [7:0] REG_PORT_ID = 8'h14;

   // control fields and reset values
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MF_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam logic [11:0] SIZE_RST = 12'h840;
   localparam logic [23:0] PORT_ID_RST = 24'h00_0001;  // arbitrary value

   // buffer parameter word: reserved bits sent as zero, size kept word aligned
   function automatic logic [31:0] make_param(input logic mf, input logic [11:0] size);
      make_param = {mf, 19'h0_0000, size[11:2], 2'h0};
   endfunction

endpackage
`default_nettype wire

// *** design/port_buf_requester.sv ***
// requesting end: sends a port buffer report and collects the reply
// assumes the responder answers each request with one two-word reply
`timescale 1ns/100ps
`default_nettype none
module port_buf_requester (
   input wire logic clk_sys,
   input wire logic srst,
   els_link_if.requester link,
   input wire logic start,
   input wire logic [23:0] own_id,
   input wire logic [23:0] dest_id,
   input wire logic own_multi,
   input wire logic [11:0] own_size,
   input wire logic [11:0] login_size,
   output logic busy,
   output logic done,
   output logic accepted,
   output logic [7:0] reason,
   output logic peer_multi,
   output logic [11:0] peer_size,
   output logic peer_err,
   output logic [11:0] usable_size
);
   typedef enum logic [2:0] {Q_IDLE = 3'b001, Q_SEND = 3'b010, Q_WAIT = 3'b100} q_state_t;
   typedef struct packed {
      q_state_t st;
      logic [1:0] idx;
      logic [23:0] did;
      logic [31:0] w0;
      logic busy; logic done; logic acc; logic [7:0] reason;
      logic pmf; logic [11:0] psize; logic perr; logic [11:0] usable;
      logic vld; logic [31:0] data; logic last;
   } q_t;
   q_t q_r, q_nxt;
   logic c_mf, c_ok;
   logic [11:0] c_size, c_use;
   logic rx;

   buf_param_check chk (.param(link.rpy_data), .login_size(login_size), .multi(c_mf),
      .size(c_size), .size_ok(c_ok), .usable(c_use));

   assign rx = link.rpy_vld && (link.rpy_did == own_id);

   // request framing and reply collection
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      q_nxt.vld = 1'b0;
      q_nxt.last = 1'b0;
      q_nxt.data = 32'h0000_0000;
      unique case (q_r.st)
         Q_IDLE: if (start) begin
            q_nxt.st = Q_SEND;
            q_nxt.did = dest_id;
            q_nxt.busy = 1'b1;
            q_nxt.idx = 2'h1;
            q_nxt.vld = 1'b1;
            q_nxt.data = {els_pkg::CMD_PORT_BUF, 24'h00_0000};
         end
         Q_SEND: begin
            q_nxt.vld = 1'b1;
            q_nxt.idx = q_r.idx + 2'h1;
            if (q_r.idx == 2'h1) begin
               q_nxt.data = els_pkg::make_param(own_multi, own_size);
            end else begin
               q_nxt.data = {8'h00, own_id};
               q_nxt.last = 1'b1;
               q_nxt.st = Q_WAIT;
               q_nxt.idx = 2'h0;
            end
         end
         Q_WAIT: if (rx) begin
            q_nxt.idx = q_r.idx + 2'h1;
            if (q_r.idx == 2'h0) begin
               q_nxt.w0 = link.rpy_data;
            end else if (q_r.w0[31:24] == els_pkg::ACC_CODE) begin
               q_nxt.acc = 1'b1;
               q_nxt.reason = 8'h00;
               q_nxt.pmf = c_mf;
               q_nxt.psize = c_size;
               q_nxt.perr = ~c_ok;
               q_nxt.usable = c_use;
            end else begin
               q_nxt.acc = 1'b0;
               q_nxt.reason = link.rpy_data[23:16];
            end
            // one reply closes the exchange
            if (link.rpy_last) begin
               q_nxt.st = Q_IDLE;
               q_nxt.busy = 1'b0;
               q_nxt.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         q_r <= '0;
         q_r.st <= Q_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign link.req_vld = q_r.vld;
   assign link.req_data = q_r.data;
   assign link.req_last = q_r.last;
   assign link.req_sid = own_id;
   assign link.req_did = q_r.did;
   assign busy = q_r.busy;
   assign done = q_r.done;
   assign accepted = q_r.acc;
   assign reason = q_r.reason;
   assign peer_multi = q_r.pmf;
   assign peer_size = q_r.psize;
   assign peer_err = q_r.perr;
   assign usable_size = q_r.usable;
endmodule
`default_nettype wire

// *** design/port_buf_responder.sv ***
// responding end of the port buffer report exchange, with an apb slave
// assumes requests arrive as contiguous words, one request at a time
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module port_buf_responder (
   input wire logic clk_sys,
   input wire logic srst,
   els_link_if.responder link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef enum logic [2:0] {R_IDLE = 3'b001, R_RECV = 3'b010, R_SEND = 3'b100} r_state_t;
   // whole block state; link and apb outputs sit here so they leave from flops
   typedef struct packed {
      r_state_t st;
      // counts request words taken, saturating at three so long frames cannot wrap
      logic [1:0] idx;
      logic code_ok;
      logic [31:0] param;
      logic [23:0] peer;
      logic [1:0] ctrl;
      logic [11:0] own_size;
      logic [11:0] login_size;
      logic [23:0] port_id;
      logic seen; logic pmf; logic perr;
      logic [11:0] psize; logic [11:0] usable;
      logic [15:0] acc_cnt; logic [15:0] rjt_cnt;
      logic rjt; logic [7:0] reason;
      logic vld; logic [31:0] data; logic last; logic [23:0] did;
      logic pready; logic [31:0] prdata; logic pslverr;
   } r_t;
   r_t r_r, r_nxt;
   logic c_mf, c_ok;
   logic [11:0] c_size, c_use;
   logic for_us, wr_take, rd_setup;

   // decode of the stored peer parameter word
   buf_param_check chk (.param(r_r.param), .login_size(r_r.login_size), .multi(c_mf),
      .size(c_size), .size_ok(c_ok), .usable(c_use));

   // accept frames sent to our own id or to the fabric controller id
   assign for_us = (link.req_did == r_r.port_id) || (link.req_did == els_pkg::FPORT_CTRL_ID);
   assign wr_take = psel && penable && r_r.pready && pwrite;
   assign rd_setup = psel && !penable;

   // offsets that answer; any other offset is refused with pslverr
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == els_pkg::REG_CTRL) || (a == els_pkg::REG_OWN_SIZE)
         || (a == els_pkg::REG_LOGIN_SIZE) || (a == els_pkg::REG_STATUS)
         || (a == els_pkg::REG_COUNT) || (a == els_pkg::REG_PORT_ID);
   endfunction

   always_comb begin
      r_nxt = r_r;
      r_nxt.vld = 1'b0;
      r_nxt.last = 1'b0;
      r_nxt.data = 32'h0000_0000;

      // apb: registered answer gives exactly one access cycle per transfer
      r_nxt.pready = rd_setup;
      r_nxt.pslverr = rd_setup && !mapped(paddr);
      r_nxt.prdata = 32'h0000_0000;
      // read data is picked at the setup edge so it stands through the access cycle
      if (rd_setup && !pwrite) begin
         case (paddr)
            els_pkg::REG_CTRL: r_nxt.prdata = {30'h0000_0000, r_r.ctrl};
            els_pkg::REG_OWN_SIZE: r_nxt.prdata = {20'h0_0000, r_r.own_size};
            els_pkg::REG_LOGIN_SIZE: r_nxt.prdata = {20'h0_0000, r_r.login_size};
            els_pkg::REG_STATUS: r_nxt.prdata = {4'h0, r_r.usable, 1'b0, r_r.perr,
               r_r.pmf, r_r.seen, r_r.psize};
            els_pkg::REG_COUNT: r_nxt.prdata = {r_r.rjt_cnt, r_r.acc_cnt};
            els_pkg::REG_PORT_ID: r_nxt.prdata = {8'h00, r_r.port_id};
            default: r_nxt.prdata = 32'h0000_0000;
         endcase
      end
      // writes land at the edge ending the access cycle; status and counters are read-only
      if (wr_take) begin
         case (paddr)
            els_pkg::REG_CTRL: r_nxt.ctrl = pwdata[1:0];
            els_pkg::REG_OWN_SIZE: r_nxt.own_size = pwdata[11:0];
            els_pkg::REG_LOGIN_SIZE: r_nxt.login_size = pwdata[11:0];
            els_pkg::REG_PORT_ID: r_nxt.port_id = pwdata[23:0];
            default: r_nxt.ctrl = r_r.ctrl;   // read-only or unmapped: no effect
         endcase
      end

      // link: collect request, then send one reply
      unique case (r_r.st)
         // only the first word is filtered by id; later words belong to that frame
         R_IDLE: if (link.req_vld && for_us) begin
            r_nxt.peer = link.req_sid;
            r_nxt.code_ok = (link.req_data[31:24] == els_pkg::CMD_PORT_BUF);
            r_nxt.idx = 2'h1;
            r_nxt.param = 32'h0000_0000;
            r_nxt.st = R_RECV;
            if (link.req_last) begin
               r_nxt.st = R_SEND;
               r_nxt.idx = 2'h0;
            end
         end
         R_RECV: if (link.req_vld) begin
            if (r_r.idx == 2'h1) begin
               r_nxt.param = link.req_data;
            end
            // word 2 and beyond carry nothing we act on
            if (r_r.idx != 2'h3) begin
               r_nxt.idx = r_r.idx + 2'h1;
            end
            if (link.req_last) begin
               r_nxt.st = R_SEND;
            end
         end
         R_SEND: begin
            // decision made on the first reply word, kept for the second
            if (r_r.idx != 2'h0 && r_r.idx != 2'h1 && !r_r.vld) begin
               r_nxt.idx = 2'h0;
            end
            r_nxt.vld = 1'b1;
            r_nxt.did = r_r.peer;
            if (!r_r.vld) begin
               r_nxt.seen = 1'b1;
               // a disabled service wins over every other reason, as an unsupported command
               // a wrong code, a short request or a bad peer size reject as malformed
               if (!r_r.ctrl[els_pkg::CTRL_EN_BIT]) begin
                  r_nxt.rjt = 1'b1;
                  r_nxt.reason = els_pkg::RSN_NOT_SUPP;
               end else if (!r_r.code_ok || (r_r.idx < els_pkg::REQ_WORDS) || !c_ok) begin
                  r_nxt.rjt = 1'b1;
                  r_nxt.reason = els_pkg::RSN_LOGICAL;
               end else begin
                  r_nxt.rjt = 1'b0;
                  r_nxt.reason = 8'h00;
               end
               // status follows every decision, so software sees rejected requests too
               r_nxt.pmf = c_mf;
               r_nxt.psize = c_size;
               r_nxt.perr = ~c_ok;
               r_nxt.usable = c_use;
               r_nxt.data = {(r_nxt.rjt ? els_pkg::RJT_CODE : els_pkg::ACC_CODE),
                  24'h00_0000};
            end else begin
               // second word carries the reason or our own parameter word
               // both counters wrap; one read returns them as a consistent pair
               r_nxt.last = 1'b1;
               r_nxt.st = R_IDLE;
               r_nxt.idx = 2'h0;
               if (r_r.rjt) begin
                  r_nxt.data = {8'h00, r_r.reason, 16'h0000};
                  r_nxt.rjt_cnt = r_r.rjt_cnt + 16'h0001;
               end else begin
                  r_nxt.data = els_pkg::make_param(r_r.ctrl[els_pkg::CTRL_MF_BIT],
                     r_r.own_size);
                  r_nxt.acc_cnt = r_r.acc_cnt + 16'h0001;
               end
            end
         end
      endcase
   end

   // one register for the whole state; reset takes constants only
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r_r <= '0;
         r_r.st <= R_IDLE;
         r_r.ctrl <= els_pkg::CTRL_RST;
         r_r.own_size <= els_pkg::SIZE_RST;
         r_r.login_size <= els_pkg::SIZE_RST;
         r_r.port_id <= els_pkg::PORT_ID_RST;
      end else begin
         r_r <= r_nxt;
      end
   end

   // every output comes straight from the state register
   assign link.rpy_vld = r_r.vld;
   assign link.rpy_data = r_r.data;
   assign link.rpy_last = r_r.last;
   assign link.rpy_sid = r_r.port_id;
   assign link.rpy_did = r_r.did;
   assign prdata = r_r.prdata;
   assign pready = r_r.pready;
   assign pslverr = r_r.pslverr;
endmodule
`default_nettype wire

// *** tb/els_link_sva.sv ***
// checker for the link that joins requester and responder
// assumes one clock and that it is instantiated beside the link interface
`timescale 1ns/100ps
`default_nettype none
module els_link_sva (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic req_vld,
   input wire logic [31:0] req_data,
   input wire logic req_last,
   input wire logic [23:0] req_sid,
   input wire logic rpy_vld,
   input wire logic [31:0] rpy_data,
   input wire logic rpy_last,
   input wire logic [23:0] rpy_did
);
   logic [23:0] sid_r;
   logic prev_r;
   logic first;
   // source id of the last request kept, since the reply must go back to it
   always_ff @(posedge clk_sys) begin
      prev_r <= srst ? 1'b0 : req_vld;
      if (req_vld && req_last) begin
         sid_r <= req_sid;
      end
   end
   assign first = req_vld && !prev_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   req_code_a: assert property (
      first |-> req_data == {els_pkg::CMD_PORT_BUF, 24'h00_0000})
      else $error("request word0 code wrong");
   req_len_a: assert property (
      first |-> !req_last ##1 req_vld && !req_last ##1 req_vld && req_last)
      else $error("request not three contiguous words");
   req_param_a: assert property (
      first |=> req_data[30:12] == 19'h0_0000 && req_data[1:0] == 2'h0)
      else $error("request parameter reserved bits set");
   rpy_time_a: assert property (
      req_vld && req_last |-> ##2 rpy_vld && !rpy_last ##1 rpy_vld && rpy_last)
      else $error("reply not two words two cycles after request");
   rpy_code_a: assert property (
      rpy_vld && !rpy_last |-> rpy_data == {els_pkg::ACC_CODE, 24'h00_0000}
      || rpy_data == {els_pkg::RJT_CODE, 24'h00_0000})
      else $error("reply word0 neither acceptance nor rejection");
   acc_param_a: assert property (
      rpy_vld && !rpy_last && rpy_data[31:24] == els_pkg::ACC_CODE
      |=> rpy_data[30:12] == 19'h0_0000 && rpy_data[1:0] == 2'h0)
      else $error("acceptance parameter word malformed");
   rjt_word_a: assert property (
      rpy_vld && !rpy_last && rpy_data[31:24] == els_pkg::RJT_CODE
      |=> rpy_data[31:24] == 8'h00 && rpy_data[15:0] == 16'h0000
      && (rpy_data[23:16] == els_pkg::RSN_NOT_SUPP || rpy_data[23:16] == els_pkg::RSN_LOGICAL))
      else $error("rejection word1 malformed");
   rpy_dest_a: assert property (rpy_vld |-> rpy_did == sid_r)
      else $error("reply not sent to requester");
   one_reply_a: assert property (rpy_vld && rpy_last |=> !rpy_vld [*4])
      else $error("extra reply word after last");
   acc_c: cover property (rpy_vld && rpy_data == {els_pkg::ACC_CODE, 24'h00_0000});
   nsup_c: cover property (rpy_vld && rpy_last && rpy_data[23:16] == els_pkg::RSN_NOT_SUPP);
   logic_c: cover property (rpy_vld && rpy_last && rpy_data[23:16] == els_pkg::RSN_LOGICAL);
endmodule
`default_nettype wire

// *** tb/test_els_buffer_report_responder.sv ***
// self-checking bench: both ends on one link, responder programmed over apb
// assumes zero-wait apb slave and one exchange in flight at a time
`timescale 1ns/100ps
`default_nettype none
module test_els_buffer_report_responder;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, start = 1'b0, own_multi = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic pready, pslverr, busy, done, accepted, peer_multi, peer_err;
   logic [23:0] dest_id = 24'h00_0001;
   logic [11:0] own_size = 12'h100, login_size = 12'h840, peer_size, usable_size;
   logic [7:0] reason;
   int n_fail = 0, comparisons = 0, cyc = 0, n_acc = 0, n_rej = 0;
   integer seed = 32'h0731e550;
   int rs, qs;
   els_link_if els_link_if_inst ();
   port_buf_requester port_buf_requester_inst (.clk_sys(clk_sys), .srst(srst),
      .link(els_link_if_inst.requester), .start(start), .own_id(24'h00_0a0b), .dest_id(dest_id),
      .own_multi(own_multi), .own_size(own_size), .login_size(login_size),
      .busy(busy), .done(done),
      .accepted(accepted), .reason(reason), .peer_multi(peer_multi), .peer_size(peer_size),
      .peer_err(peer_err), .usable_size(usable_size));
   port_buf_responder port_buf_responder_inst (.clk_sys(clk_sys), .srst(srst),
      .link(els_link_if_inst.responder), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   els_link_sva els_link_sva_inst (.clk_sys(clk_sys), .srst(srst),
      .req_vld(els_link_if_inst.req_vld), .req_data(els_link_if_inst.req_data),
      .req_last(els_link_if_inst.req_last), .req_sid(els_link_if_inst.req_sid),
      .rpy_vld(els_link_if_inst.rpy_vld), .rpy_data(els_link_if_inst.rpy_data),
      .rpy_last(els_link_if_inst.rpy_last), .rpy_did(els_link_if_inst.rpy_did));
   always #25 clk_sys = !clk_sys;
   // hang guard: a run of a few thousand cycles is far beyond the tests
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; the edge first ensures no signal is driven twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one exchange, checked against an integer model of both ends
   task automatic run(input int en, rmf, rsz, qmf, qsz, lg, input logic [23:0] d);
      int ok, acc;
      logic [27:0] st_exp;
      apb(1'b1, els_pkg::REG_CTRL, {30'h0, rmf[0], en[0]});
      apb(1'b1, els_pkg::REG_OWN_SIZE, rsz);
      start <= 1'b1;
      dest_id <= d;
      own_multi <= qmf[0];
      own_size <= qsz[11:0];
      login_size <= lg[11:0];
      @(posedge clk_sys);
      start <= 1'b0;
      @(posedge clk_sys);
      chk(busy, 1'b1);
      do @(posedge clk_sys); while (done !== 1'b1);
      ok = qsz >= 256 && qsz <= 2112 && qsz % 4 == 0;
      acc = en && ok;
      chk(accepted, acc);
      chk(busy, 1'b0);
      if (acc) begin
         chk(peer_multi, rmf);
         chk(peer_size, rsz);
         chk(peer_err, rsz < 256 || rsz > 2112 || rsz % 4);
         chk(usable_size, rsz < lg ? rsz : lg);
      end else chk(reason, en ? els_pkg::RSN_LOGICAL : els_pkg::RSN_NOT_SUPP);
      n_acc += acc;
      n_rej += !acc;
      apb(1'b0, els_pkg::REG_STATUS, 32'h0);
      // responder login size stays at its reset value, so usable is capped there
      st_exp = {(qsz < 2112 ? qsz[11:0] : els_pkg::SIZE_RST), 1'b0, !ok, qmf[0], 1'b1, qsz[11:0]};
      chk(q, {4'h0, st_exp});
      apb(1'b0, els_pkg::REG_COUNT, 32'h0);
      chk(q, {n_rej[15:0], n_acc[15:0]});
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      // reset values, then an unmapped offset that must be refused
      apb(1'b0, els_pkg::REG_CTRL, 32'h0);
      chk(q, els_pkg::CTRL_RST);
      apb(1'b0, els_pkg::REG_OWN_SIZE, 32'h0);
      chk(q, els_pkg::SIZE_RST);
      apb(1'b0, els_pkg::REG_PORT_ID, 32'h0);
      chk(q, els_pkg::PORT_ID_RST);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, err}, 32'h0000_0001);
      chk(q, 32'h0000_0000);
      apb(1'b1, els_pkg::REG_PORT_ID, 32'h0012_3456);
      // the write lands at the edge that ended the access, so look one edge later
      @(posedge clk_sys);
      chk(els_link_if_inst.rpy_sid, 24'h12_3456);
      $display("test registers done");
      // random legal exchanges, to the peer and to the fabric controller id
      for (int i = 0; i < 8; i++) begin
         rs = 256 + 4 * (($random(seed) & 32'h7fff_ffff) % 465);
         qs = 256 + 4 * (($random(seed) & 32'h7fff_ffff) % 465);
         run(1, $random(seed) & 1, rs, $random(seed) & 1, qs, $random(seed) & 32'h0fff,
            i % 2 ? els_pkg::FPORT_CTRL_ID : 24'h12_3456);
      end
      $display("test accept done");
      run(0, 1, 2112, 1, 512, 2048, 24'h12_3456);
      run(1, 0, 1024, 0, 252, 2048, 24'h12_3456);
      run(1, 1, 1024, 1, 2116, 2048, 24'h12_3456);
      $display("test reject done");
      run(1, 1, 2304, 0, 256, 4095, els_pkg::FPORT_CTRL_ID);
      run(1, 0, 252, 1, 2112, 100, 24'h12_3456);
      $display("test peer size error done");
      summarize();
   end
endmodule
`default_nettype wire
